//--- design/vcc_defs.svh
`ifndef VCC_DEFS_SVH
`define VCC_DEFS_SVH
// ==========================================
// Register map and reset values
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_STATE 8'h0C
`define CTRL_RESET 32'h0000_0000
`define CTRL_WMASK 32'hBFFF_F7DF
// ==========================================
// Control register fields
`define B_EDGE 31
`define B_WID_HI 29
`define B_WID_LO 28
`define B_IVL_HI 27
`define B_IVL_LO 16
`define B_FID_INV 15
`define B_VV_INV 14
`define B_HV_INV 13
`define B_STORE 12
`define B_SCAN 10
`define B_VAUX 9
`define B_HAUX 8
`define B_LAYOUT 4
`define B_RAW 2
// ==========================================
// Interrupt status bits and bus answers
`define IRQ_W 2
`define IRQ_LINE 0
`define IRQ_FRAME 1
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3
// ==========================================
// Pixel pins, widths and timing codes
`define PIN_W 16
`define PIN_CLK 15
`define PIN_FID 14
`define PIN_VV 13
`define PIN_HV 12
`define PIX_W 12
`define WID_8 2'h0
`define WID_10 2'h1
`define MASK_8 12'h0FF
`define MASK_10 12'h3FF
`define MASK_12 12'hFFF
`define CODE_FF 8'hFF
`define CODE_00 8'h00
`define XY_H 4
`define XY_V 5
`define XY_F 6
`define ST_FIELD 16
`define ST_VBLANK 17
`define ST_ACTIVE 18
`endif

//--- design/vcc_pkg.sv
// ==========================================
// Shared types
package vcc_pkg;
   typedef enum logic [1:0] {KIND_IMAGE, KIND_HAUX, KIND_VAUX} store_kind_t;
   typedef enum logic {IN_BLANK, IN_ACTIVE} region_t;
   typedef struct packed {
      logic fid;
      logic vvalid;
      logic hvalid;
      logic [11:0] data;
   } pixel_sample_t;
   typedef struct packed {
      store_kind_t kind;
      logic frame_store;
      logic field;
      logic [11:0] data;
   } mem_write_t;
endpackage : vcc_pkg

//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcc_defs.svh"
module pin_sync (
   input wire logic aclk,
   input wire logic [`PIN_W-1:0] pins,
   output logic [`PIN_W-1:0] synced
);
   // ==========================================
   // Two flops per pin, first stage read only by the second
   genvar i;
   generate
      for (i = 0; i < `PIN_W; i++)
      begin : g_bit
         logic meta;
         always_ff @(posedge aclk)
         begin
            meta <= pins[i];
            synced[i] <= meta;
         end
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

//--- design/timing_code_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcc_defs.svh"
module timing_code_detect (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic step,
   input wire logic [7:0] word_in,
   output logic [7:0] word_out,
   output logic is_code,
   output logic is_xy
);
   // ==========================================
   // Four-word delay so whole code words can be marked
   logic [7:0] pipe [0:3];
   logic [3:0] mark;
   logic [3:0] xy;
   logic found;

   assign found = step && pipe[2] == `CODE_FF && pipe[1] == `CODE_00
      && pipe[0] == `CODE_00;

   // Shift words and marks on each link sample
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int k = 0; k < 4; k++)
            pipe[k] <= 8'h00;
         mark <= 4'h0;
         xy <= 4'h0;
      end
      else if (step)
      begin
         pipe[0] <= word_in;
         for (int k = 1; k < 4; k++)
            pipe[k] <= pipe[k-1];
         mark <= found ? 4'hF : {mark[2:0], 1'b0};
         xy <= found ? 4'h1 : {xy[2:0], 1'b0};
      end
   end

   assign word_out = pipe[3];
   assign is_code = mark[3];
   assign is_xy = xy[3];
endmodule : timing_code_detect
`default_nettype wire

//--- design/video_capture_channel_control.sv
// Contract
// - Edge select bit: 0 rising, 1 falling
// - Edge select only driven out, not applied
// - Line interrupt every programmed number of lines; the code counts line ends only with the raw bit set
// - Field ID inverted when its bit set
// - Vertical valid inverted when its bit set
// - Horizontal valid inverted when its bit set
// - Field/frame storage only interlaced sub-picture
// - Progressive always stores frame based
// - Vertical blanking words stored when enabled
// - Horizontal blanking words stored when enabled
// - No horizontal blanking writes when disabled
// - Raw settings honoured only for format 2/3
// - Format 0/1 embedded sync, 2/3 raw
// - Layout bit: raster or sub-picture
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vcc_defs.svh"
module video_capture_channel_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic pix_clk,
   input wire logic pix_fid,
   input wire logic pix_vvalid,
   input wire logic pix_hvalid,
   input wire logic [11:0] pix_data,
   output logic sample_edge_select,
   output logic [1:0] pixel_width,
   output logic frame_store,
   output logic mem_wr_valid,
   output vcc_pkg::mem_write_t mem_wr,
   output logic irq
);
   // ==========================================
   // Register bus
   logic [31:0] ctrl;
   logic [`IRQ_W-1:0] mask;
   logic [`IRQ_W-1:0] status;
   logic [`IRQ_W-1:0] events;
   logic [`IRQ_W-1:0] w1c;
   logic [7:0] aw_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic [31:0] be_mask;
   logic wr_go;
   logic wr_hit;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic raw;
   logic [11:0] line_cnt;
   logic bt_field;
   logic vblank;
   vcc_pkg::region_t region;

   // Byte enables widened to a bit mask
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_lane
         assign be_mask[8*i +: 8] = {8{ws_q[i]}};
      end
   endgenerate

   assign wr_go = !awready && !wready && !bvalid;
   assign wr_hit = aw_q == `OFS_CTRL || aw_q == `OFS_STATUS || aw_q == `OFS_MASK;
   assign raw = ctrl[`B_RAW];

   // Address and data taken in either order, answer follows both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `AXI_OKAY;
         aw_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wd_q <= wdata;
            ws_q <= wstrb;
            wready <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `AXI_OKAY : `AXI_DECERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Control register, reserved and read-only bits stay zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= `CTRL_RESET;
      else if (wr_go && aw_q == `OFS_CTRL)
         ctrl <= (ctrl & ~(be_mask & `CTRL_WMASK)) | (wd_q & be_mask & `CTRL_WMASK);
   end

   // Interrupt enable register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask <= '0;
      else if (wr_go && aw_q == `OFS_MASK)
         mask <= (mask & ~be_mask[`IRQ_W-1:0]) | (wd_q[`IRQ_W-1:0] & be_mask[`IRQ_W-1:0]);
   end

   // Sticky status, write one to clear, a new event wins
   assign w1c = (wr_go && aw_q == `OFS_STATUS) ? wd_q[`IRQ_W-1:0] & be_mask[`IRQ_W-1:0] : '0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status <= '0;
         irq <= 1'b0;
      end
      else
      begin
         status <= (status & ~w1c) | events;
         irq <= |(status & mask);
      end
   end

   // Read data selection
   always_comb
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (araddr)
         `OFS_CTRL: rd_mux = ctrl;
         `OFS_STATUS: rd_mux[`IRQ_W-1:0] = status;
         `OFS_MASK: rd_mux[`IRQ_W-1:0] = mask;
         `OFS_STATE:
         begin
            rd_mux[11:0] = line_cnt;
            rd_mux[`ST_FIELD] = bt_field;
            rd_mux[`ST_VBLANK] = vblank;
            rd_mux[`ST_ACTIVE] = region == vcc_pkg::IN_ACTIVE;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `AXI_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= rd_hit ? `AXI_OKAY : `AXI_DECERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ==========================================
   // Static control outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sample_edge_select <= 1'b0;
         pixel_width <= `WID_8;
         frame_store <= 1'b0;
      end
      else
      begin
         sample_edge_select <= ctrl[`B_EDGE] & raw;
         pixel_width <= raw ? ctrl[`B_WID_HI:`B_WID_LO] : `WID_8;
         frame_store <= ctrl[`B_SCAN] | (ctrl[`B_LAYOUT] & ctrl[`B_STORE]);
      end
   end

   // ==========================================
   // Link sampling
   logic [`PIN_W-1:0] s_vec;
   logic clk_d;
   logic pix_step;
   logic smp_step;
   logic det_step;
   logic [11:0] wmask;
   vcc_pkg::pixel_sample_t smp;
   logic hv_prev;
   logic vv_prev;
   logic [7:0] det_word;
   logic det_code;
   logic det_xy;

   pin_sync u_sync (
      .aclk(aclk),
      .pins({pix_clk, pix_fid, pix_vvalid, pix_hvalid, pix_data}),
      .synced(s_vec)
   );

   timing_code_detect u_codes (
      .aclk(aclk),
      .aresetn(aresetn),
      .step(pix_step),
      .word_in(s_vec[7:0]),
      .word_out(det_word),
      .is_code(det_code),
      .is_xy(det_xy)
   );

   assign pix_step = s_vec[`PIN_CLK] && !clk_d;

   // Width mask for raw samples, embedded sync stays 8 bits
   always_comb
   begin
      wmask = `MASK_12;
      if (!raw || ctrl[`B_WID_HI:`B_WID_LO] == `WID_8)
         wmask = `MASK_8;
      else if (ctrl[`B_WID_HI:`B_WID_LO] == `WID_10)
         wmask = `MASK_10;
   end

   // Capture one sample per rising link clock edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_d <= 1'b0;
         smp_step <= 1'b0;
         det_step <= 1'b0;
         smp <= '0;
      end
      else
      begin
         clk_d <= s_vec[`PIN_CLK];
         smp_step <= pix_step;
         det_step <= pix_step;
         if (pix_step)
         begin
            smp.fid <= s_vec[`PIN_FID] ^ (raw & ctrl[`B_FID_INV]);
            smp.vvalid <= s_vec[`PIN_VV] ^ (raw & ctrl[`B_VV_INV]);
            smp.hvalid <= s_vec[`PIN_HV] ^ (raw & ctrl[`B_HV_INV]);
            smp.data <= s_vec[`PIX_W-1:0] & wmask;
         end
      end
   end

   // ==========================================
   // Line and frame events
   logic line_end;
   logic line_hit;
   logic bt_frame;

   assign line_end = raw && smp_step && hv_prev && !smp.hvalid;
   assign line_hit = {1'b0, line_cnt} + 13'h0001 >= {1'b0, ctrl[`B_IVL_HI:`B_IVL_LO]};
   assign bt_frame = !raw && det_step && det_xy && vblank && !det_word[`XY_V];
   assign events[`IRQ_LINE] = line_end && line_hit;
   assign events[`IRQ_FRAME] = (raw && smp_step && !vv_prev && smp.vvalid) || bt_frame;

   // Count line ends against the interval
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         line_cnt <= 12'h000;
         hv_prev <= 1'b0;
         vv_prev <= 1'b0;
      end
      else if (smp_step)
      begin
         hv_prev <= smp.hvalid;
         vv_prev <= smp.vvalid;
         if (line_end)
            line_cnt <= line_hit ? 12'h000 : line_cnt + 12'h001;
      end
   end

   // Embedded timing codes set region, blanking and field
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         region <= vcc_pkg::IN_BLANK;
         vblank <= 1'b1;
         bt_field <= 1'b0;
      end
      else if (det_step && det_xy && !raw)
      begin
         region <= det_word[`XY_H] ? vcc_pkg::IN_BLANK : vcc_pkg::IN_ACTIVE;
         vblank <= det_word[`XY_V];
         bt_field <= det_word[`XY_F];
      end
   end

   // ==========================================
   // Memory write requests
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mem_wr_valid <= 1'b0;
         mem_wr <= '0;
      end
      else
      begin
         mem_wr_valid <= 1'b0;
         mem_wr.frame_store <= frame_store;
         if (raw && smp_step && smp.hvalid && smp.vvalid)
         begin
            mem_wr_valid <= 1'b1;
            mem_wr.kind <= vcc_pkg::KIND_IMAGE;
            mem_wr.field <= smp.fid;
            mem_wr.data <= smp.data;
         end
         else if (!raw && det_step && !det_code)
         begin
            mem_wr.field <= bt_field;
            mem_wr.data <= {4'h0, det_word};
            case (region)
               vcc_pkg::IN_ACTIVE:
               begin
                  mem_wr_valid <= !vblank || ctrl[`B_VAUX];
                  mem_wr.kind <= vblank ? vcc_pkg::KIND_VAUX : vcc_pkg::KIND_IMAGE;
               end
               vcc_pkg::IN_BLANK:
               begin
                  mem_wr_valid <= ctrl[`B_HAUX];
                  mem_wr.kind <= vcc_pkg::KIND_HAUX;
               end
               default: mem_wr_valid <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================
   // Checks
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence seq_line_hit;
      line_end && line_hit;
   endsequence

   a_edge_out_gate: assert property (
      sample_edge_select == $past(ctrl[`B_EDGE] && ctrl[`B_RAW]))
      else $error("edge select output wrong");
   a_line_int_fire: assert property (
      seq_line_hit |=> status[`IRQ_LINE] && line_cnt == 12'h000)
      else $error("line interrupt missed");
   a_fid_invert: assert property (
      pix_step |=> smp.fid == ($past(s_vec[`PIN_FID]) ^ $past(raw && ctrl[`B_FID_INV])))
      else $error("field id inversion wrong");
   a_vvalid_invert: assert property (
      pix_step |=> smp.vvalid == ($past(s_vec[`PIN_VV]) ^ $past(raw && ctrl[`B_VV_INV])))
      else $error("vertical valid inversion wrong");
   a_hvalid_invert: assert property (
      pix_step |=> smp.hvalid == ($past(s_vec[`PIN_HV]) ^ $past(raw && ctrl[`B_HV_INV])))
      else $error("horizontal valid inversion wrong");
   a_raster_field: assert property (
      !ctrl[`B_SCAN] && !ctrl[`B_LAYOUT] |=> !frame_store)
      else $error("raster interlaced not field based");
   a_prog_frame: assert property (
      ctrl[`B_SCAN] |=> frame_store)
      else $error("progressive not frame based");
   a_vaux_gate: assert property (
      mem_wr_valid && mem_wr.kind == vcc_pkg::KIND_VAUX |-> $past(ctrl[`B_VAUX]))
      else $error("vertical blanking write while disabled");
   a_haux_gate: assert property (
      mem_wr_valid && mem_wr.kind == vcc_pkg::KIND_HAUX |-> $past(ctrl[`B_HAUX]))
      else $error("horizontal blanking write while disabled");
   a_width_eight: assert property (
      pix_step && (!raw || ctrl[`B_WID_HI:`B_WID_LO] == `WID_8) |=> smp.data[11:8] == 4'h0)
      else $error("8 bit sample not masked");
   a_irq_level: assert property (
      ##1 irq == $past(|(status & mask)))
      else $error("interrupt level wrong");
endmodule : video_capture_channel_control
`default_nettype wire

//--- verification/pix_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Camera side model driving the pixel pins
module pix_source (
   output logic pix_clk,
   output logic pix_fid,
   output logic pix_vvalid,
   output logic pix_hvalid,
   output logic [11:0] pix_data
);
   // Link clock rests low outside frames
   initial
   begin
      pix_clk = 1'b0;
      {pix_fid, pix_vvalid, pix_hvalid, pix_data} = 15'h4000;
   end
   // One word per 48 ns link clock, changed while the clock is low
   task automatic word(input logic [14:0] s);
      {pix_fid, pix_vvalid, pix_hvalid, pix_data} = s;
      #24 pix_clk = 1'b1;
      #24 pix_clk = 1'b0;
   endtask : word
   // Released data lines no longer hold the last word
   task automatic idle();
      pix_data = ~pix_data;
   endtask : idle
endmodule : pix_source
`default_nettype wire

//--- verification/test_video_capture_channel_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcc_defs.svh"
// ==========================================
// Bench for the capture channel control block
module test_video_capture_channel_control;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, edge_sel, frame_store, mem_wr_valid, irq;
   logic pix_clk, pix_fid, pix_vvalid, pix_hvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, pixel_width;
   logic [11:0] pix_data;
   vcc_pkg::mem_write_t mem_wr;
   vcc_pkg::mem_write_t got[$];
   vcc_pkg::mem_write_t exp[$];
   int mismatches, checks_done;
   logic [31:0] cfg [6] = '{32'h8000_0004, 32'h9000_1004, 32'h2000_1014, 32'hA000_0402,
      32'h0000_0410, 32'h0000_0014};
   logic [3:0] exo [6] = '{4'h8, 4'hA, 4'h5, 4'h1, 4'h1, 4'h0};
   logic [7:0] strm [28] = '{8'hFF, 8'h00, 8'h00, 8'h90, 8'h11, 8'h22, 8'hFF, 8'h00, 8'h00,
      8'h80, 8'h33, 8'hFF, 8'h00, 8'h00, 8'h90, 8'hFF, 8'h00, 8'h00, 8'hA0, 8'h44, 8'hFF,
      8'h00, 8'h00, 8'hB0, 8'hFF, 8'h00, 8'h00, 8'h90};
   video_capture_channel_control i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .pix_clk(pix_clk), .pix_fid(pix_fid), .pix_vvalid(pix_vvalid),
      .pix_hvalid(pix_hvalid), .pix_data(pix_data), .sample_edge_select(edge_sel),
      .pixel_width(pixel_width), .frame_store(frame_store), .mem_wr_valid(mem_wr_valid),
      .mem_wr(mem_wr), .irq(irq));
   pix_source i_src (.pix_clk(pix_clk), .pix_fid(pix_fid), .pix_vvalid(pix_vvalid),
      .pix_hvalid(pix_hvalid), .pix_data(pix_data));
   // 200 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Collect every stored word
   always @(posedge aclk)
   begin
      if (mem_wr_valid === 1'b1)
         got.push_back(mem_wr);
   end
   // ==========================================
   // Checking and ending
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_writes();
      chk(got.size(), exp.size());
      foreach (exp[i])
         if (i < got.size()) chk({16'h0000, got[i]}, {16'h0000, exp[i]});
      got.delete();
      exp.delete();
   endtask : chk_writes
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   function automatic vcc_pkg::mem_write_t mk(input vcc_pkg::store_kind_t k,
         input logic [11:0] d);
      mk = '{kind: k, frame_store: 1'b0, field: 1'b0, data: d};
   endfunction : mk
   // ==========================================
   // Register bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      @(posedge aclk);
      ad = 1'b0;
      dd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1)
         begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
         input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata & m, e & m);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd
   // ==========================================
   // Pixel traffic
   task automatic line_raw();
      logic [11:0] px [3] = '{12'hA5C, 12'h3F1, 12'hFFF};
      foreach (px[i])
      begin
         i_src.word({3'b100, px[i]});
         exp.push_back(mk(vcc_pkg::KIND_IMAGE, px[i]));
      end
      repeat (2) i_src.word(15'h5000);
   endtask : line_raw
   task automatic stream(input logic e);
      foreach (strm[i]) i_src.word({7'h70, strm[i]});
      if (e) exp.push_back(mk(vcc_pkg::KIND_HAUX, 12'h011));
      if (e) exp.push_back(mk(vcc_pkg::KIND_HAUX, 12'h022));
      exp.push_back(mk(vcc_pkg::KIND_IMAGE, 12'h033));
      if (e) exp.push_back(mk(vcc_pkg::KIND_VAUX, 12'h044));
      repeat (10) @(posedge aclk);
      chk_writes();
   endtask : stream
   // Hang guard
   initial
   begin
      #200000;
      mismatches++;
      stop_test();
   end
   // ==========================================
   // Test sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFS_CTRL, `CTRL_RESET, 32'hFFFF_FFFF, `AXI_OKAY);
      rd(8'h40, 32'h0, 32'h0, `AXI_DECERR);
      wr(8'h40, 32'hFFFF_FFFF, `AXI_DECERR);
      wr(`OFS_STATE, 32'h0, `AXI_DECERR);
      wr(`OFS_CTRL, 32'h2002_E004, `AXI_OKAY);
      line_raw();
      rd(`OFS_STATUS, 32'h2, 32'h3, `AXI_OKAY);
      rd(`OFS_STATE, 32'h1, 32'hFFF, `AXI_OKAY);
      line_raw();
      rd(`OFS_STATUS, 32'h3, 32'h3, `AXI_OKAY);
      chk_writes();
      chk({31'h0, irq}, 32'h0);
      wr(`OFS_MASK, 32'h1, `AXI_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(`OFS_STATUS, 32'h3, `AXI_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(`OFS_STATUS, 32'h0, 32'h3, `AXI_OKAY);
      wr(`OFS_CTRL, 32'hFFFF_FFFF, `AXI_OKAY);
      rd(`OFS_CTRL, 32'hFFFF_FFFF & ~32'h4000_0820, 32'hFFFF_FFFF, `AXI_OKAY);
      // Only the lowest byte lane may change
      wstrb <= 4'h1;
      wr(`OFS_CTRL, 32'h0000_0000, `AXI_OKAY);
      rd(`OFS_CTRL, `CTRL_WMASK & 32'hFFFF_FF00, 32'hFFFF_FFFF, `AXI_OKAY);
      wstrb <= 4'hF;
      foreach (cfg[i])
      begin
         wr(`OFS_CTRL, cfg[i], `AXI_OKAY);
         repeat (3) @(posedge aclk);
         chk({28'h0, edge_sel, pixel_width, frame_store}, {28'h0, exo[i]});
      end
      wr(`OFS_CTRL, 32'h0000_0000, `AXI_OKAY);
      stream(1'b0);
      wr(`OFS_CTRL, 32'h0000_0300, `AXI_OKAY);
      stream(1'b1);
      i_src.idle();
      stop_test();
   end
endmodule : test_video_capture_channel_control
`default_nettype wire
